/* design/ddr2_wr_ctrl.sv */
// Memory controller end: AXI4-Lite registers, command spacing, data drive
`timescale 1ns/10ps
module ddr2_wr_ctrl (
  // Link
  ddr2_wr_if.ctrl     link,
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import ddr2_wr_pkg::*;

  // Issue states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } st_t;

  st_t         st_q;                       // Issue state
  logic [12:0] mode_q;                     // Mode shadow
  logic [31:0] cmdReg_q;                   // Pending command word
  logic [31:0] wd_q [4];                   // Burst data, one word per pair
  logic        awHave_q, wHave_q;          // Address / data held
  logic [7:0]  awAddr_q;                   // Held write address
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;           // Answers
  logic [31:0] rdata_q;                    // Read data
  logic        doWrite, arTake, refused_q;
  logic        bl8;                        // Burst of eight
  logic [3:0]  wl;                         // Write latency
  logic [5:0]  half;                       // BL/2
  cmd_t        op;                         // Pending operation
  logic [2:0]  opBank;                     // Pending bank
  logic        ok;                         // Spacing allows issue
  logic        issue;                      // Command goes out now
  logic        wrGapIdle, wtrIdle;         // Device-wide timers
  logic [NBANK-1:0] wrIdle, wrLoad;        // Per-bank recovery
  logic [PIPE-1:0] dSlot_q;                // Drive delay line
  logic        dAct_q;                     // Driving a burst
  logic [1:0]  dBeat_q;                    // Pair being driven
  logic [1:0]  curBeat;                    // Pair index this cycle
  logic        dNow;                       // Drive this cycle

  assign bl8    = mode_q[MR_BL8];
  assign wl     = wlOf(mode_q[MR_AL_LO +: 3], mode_q[MR_CL_LO +: 3]);
  assign half   = bl8 ? 6'h04 : 6'h02;
  assign op     = cmd_t'(cmdReg_q[CR_OP_LO +: 3]);
  assign opBank = cmdReg_q[CR_BA_LO +: 3];
  assign doWrite = awHave_q && wHave_q && !bvalid_q;
  assign arTake  = arvalid && arready_q;

  // Write channel: address and data taken in either order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHave_q <= 1'b0; wHave_q <= 1'b0; awAddr_q <= 8'h00;
      awready_q <= 1'b1; wready_q <= 1'b1;
      bvalid_q <= 1'b0; bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awHave_q <= 1'b1; awAddr_q <= awaddr; awready_q <= 1'b0;
      end
      if (wvalid && wready_q)
      begin
        wHave_q <= 1'b1; wready_q <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid_q <= 1'b1;
        // Unmapped address or a command while one is pending
        bresp_q  <= ((awAddr_q > REG_STATUS) || awAddr_q[1:0] != 2'h0 ||
                     (awAddr_q == REG_CMD && st_q != ST_IDLE)) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0; awHave_q <= 1'b0; wHave_q <= 1'b0;
        awready_q <= 1'b1; wready_q <= 1'b1;
      end
    end
  end

  // Register stores; a command write arms the issue machine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q <= MODE_RST; cmdReg_q <= 32'h0000_0000; refused_q <= 1'b0;
      for (int i = 0; i < 4; i++)
        wd_q[i] <= 32'h0000_0000;
    end
    else if (doWrite && wstrb == 4'hF)
    begin
      if (awAddr_q == REG_MODE)
        mode_q <= wdata[12:0];
      else if (awAddr_q == REG_CMD && st_q == ST_IDLE)
        cmdReg_q <= wdata;
      else if (awAddr_q == REG_CMD)
        refused_q <= 1'b1;
      else if (awAddr_q >= REG_WDATA0 && awAddr_q < REG_STATUS)
        wd_q[2'(8'(awAddr_q - REG_WDATA0) >> 2)] <= wdata;
      else if (awAddr_q == REG_STATUS)
        refused_q <= 1'b0;
    end
  end

  // Spacing check against the timers
  always_comb
  begin
    case (op)
      CMD_WRITE: ok = wrGapIdle;
      CMD_READ:  ok = wtrIdle && !dAct_q && (dSlot_q == '0);
      CMD_PRE:   ok = (cmdReg_q[CR_AP] ? (&wrIdle) : wrIdle[opBank]) &&
                      !dAct_q && (dSlot_q == '0);
      CMD_ACT:   ok = !dAct_q && (dSlot_q == '0);
      CMD_MODE:  ok = (&wrIdle) && wtrIdle && !dAct_q && (dSlot_q == '0);
      default:   ok = 1'b1;
    endcase
  end

  assign issue = (st_q == ST_WAIT) && ok;

  // Issue machine and command pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE; link.cmd <= CMD_NOP; link.ba <= 3'h0; link.addr <= 13'h0000;
    end
    else
    begin
      link.cmd <= CMD_NOP;
      case (st_q)
        ST_IDLE:
          if (doWrite && awAddr_q == REG_CMD && wstrb == 4'hF)
            st_q <= ST_WAIT;
        ST_WAIT:
          if (issue)
          begin
            st_q      <= ST_IDLE;
            link.cmd  <= op;
            link.ba   <= opBank;
            link.addr <= (op == CMD_MODE) ? mode_q :
                         {2'h0, cmdReg_q[CR_AP], 7'h00, cmdReg_q[CR_CO_LO +: 3]};
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Timers start when a write leaves; counts are from the full burst
  always_comb
  begin
    wrLoad = '0;
    if (issue && op == CMD_WRITE)
      wrLoad[opBank] = 1'b1;
  end

  gap_timer u_gap (
    .clk   (clk), .rst (rst), .load (issue && op == CMD_WRITE),
    .value (6'(half)), .idle (wrGapIdle)
  );
  gap_timer u_wtr (
    .clk   (clk), .rst (rst), .load (issue && op == CMD_WRITE),
    .value (6'({2'h0, wl} + half + 6'(TWTR_CYC))), .idle (wtrIdle)
  );
  for (genvar b = 0; b < NBANK; b++)
  begin : g_wr
    gap_timer u_wr (
      .clk   (clk), .rst (rst), .load (wrLoad[b]),
      .value (6'({2'h0, wl} + half + 6'(TWR_CYC))), .idle (wrIdle[b])
    );
  end

  // Data drive: pairs follow the command by write latency when wl is 2 or more; with wl of 1 they follow two cycles after it
  assign dNow    = dSlot_q[0] || dAct_q;
  assign curBeat = dSlot_q[0] ? 2'h0 : dBeat_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dSlot_q <= '0; dAct_q <= 1'b0; dBeat_q <= 2'h0;
      link.dqOut <= 32'h0000_0000; link.dqOe <= 1'b0;
      link.dqs <= 2'h0; link.dm <= 4'h0;
    end
    else
    begin
      // The command edge plus wl-1 shifts lands on the first data cycle
      dSlot_q <= (dSlot_q >> 1) |
                 ((link.cmd == CMD_WRITE && wl >= 4'h2) ? (PIPE'(1) << (wl - 4'h2)) : '0);
      if (link.cmd == CMD_WRITE && wl == 4'h1)
        dAct_q <= 1'b1;
      link.dqOe  <= 1'b0;
      link.dqs   <= 2'h0;
      if (dNow)
      begin
        link.dqOe  <= 1'b1;
        link.dqs   <= 2'h3;
        link.dqOut <= wd_q[curBeat];
        dAct_q     <= (curBeat != (bl8 ? 2'h3 : 2'h1));
        dBeat_q    <= 2'(curBeat + 2'h1);
      end
    end
  end

  // Read channel
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arready_q <= 1'b1; rvalid_q <= 1'b0; rdata_q <= 32'h0000_0000; rresp_q <= RESP_OKAY;
    end
    else if (arTake)
    begin
      arready_q <= 1'b0; rvalid_q <= 1'b1; rresp_q <= RESP_OKAY;
      case (araddr)
        REG_MODE:   rdata_q <= {19'h0, mode_q};
        REG_CMD:    rdata_q <= cmdReg_q;
        REG_STATUS: rdata_q <= {20'h0, wrIdle, wtrIdle, dNow, refused_q, st_q == ST_WAIT};
        default:
          if (araddr >= REG_WDATA0 && araddr < REG_STATUS && araddr[1:0] == 2'h0)
            rdata_q <= wd_q[2'(8'(araddr - REG_WDATA0) >> 2)];
          else
          begin
            rdata_q <= 32'h0000_0000; rresp_q <= RESP_SLVERR;
          end
      endcase
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0; arready_q <= 1'b1;
    end
  end

  assign awready = awready_q; assign wready = wready_q;
  assign bvalid  = bvalid_q;  assign bresp  = bresp_q;
  assign arready = arready_q; assign rvalid = rvalid_q;
  assign rdata   = rdata_q;   assign rresp  = rresp_q;
endmodule : ddr2_wr_ctrl

/* design/ddr2_wr_device.sv */
// Memory device end: mode, write bursts, byte strobes, auto precharge
//
// How it works
// - Outside a burst, data ignored, no drive
// - Writes may stream BL/2 cycles apart; the controller's gap timer spaces them BL/2+1
// - Controller never interrupts burst of four
// - Only a write truncates burst of eight
// - Interrupting write comes two cycles later
// - No precharge between interrupting write pair
// - Precharge after interrupt uses untruncated end
// - Interrupting write: any bank, either precharge
// - Read waits max(2, tWTR) after write
// - tWTR counted from edge after last pair
// - Write recovery before same-bank precharge
// - Other-bank precharge needs no write recovery
// - Write-to-read spacing only inside one device
// - Auto-precharge write then read: CL-1+BL/2+tWTR
// - Auto-precharge write: write BL/2, others 1
// - Mode bits 9..11 hold write recovery cycles
// - Each strobe captures its own byte lane
// - Writes any bank, elements in burst order
// - Write latency equals read latency minus one
// - Elements captured on successive strobe edges
// - Auto precharge closes row after burst
`timescale 1ns/10ps
module ddr2_wr_device (
  // Link
  ddr2_wr_if.dev      link,
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Storage peek
  input  wire logic [2:0] rdBank,
  input  wire logic [2:0] rdCol,
  output logic [15:0] rdData,
  // State
  output logic [7:0]  bankOpen,
  output logic        illegalCmd
);
  import ddr2_wr_pkg::*;

  // Burst engine states
  typedef enum logic [1:0] {
    BS_IDLE  = 2'b01,
    BS_BURST = 2'b10
  } bstate_t;

  logic [12:0] mode_q;                 // Mode word as loaded
  logic        bl8;                    // Burst of eight selected
  logic [3:0]  wl;                     // Write latency
  logic [2:0]  wrCyc;                  // Write recovery cycles
  logic [PIPE-1:0] pValid_q;           // Delay line: write pending
  logic [2:0]  pBank_q [PIPE];         // Delay line: bank
  logic [2:0]  pCol_q  [PIPE];         // Delay line: start column
  logic        pAp_q   [PIPE];         // Delay line: auto precharge
  bstate_t     bst_q;                  // Burst engine state
  logic [2:0]  cBank_q;                // Current burst bank
  logic [2:0]  cCol_q;                 // Current burst start column
  logic        cAp_q;                  // Current burst auto precharge
  logic [1:0]  beat_q;                 // Next pair index
  logic        start;                  // Delay line delivers a burst
  logic        active;                 // A data pair is due this cycle
  logic [2:0]  aBank;                  // Bank of the pair
  logic [2:0]  aCol;                   // Start column of the pair
  logic [1:0]  aBeat;                  // Pair index
  logic        lastBeat;               // Pair closes the burst
  logic        busy;                   // Any write pending or running
  logic [15:0] mem_q [NBANK*NCOL];     // Storage
  logic [NBANK-1:0] apArm_q;           // Auto precharge waiting
  logic [NBANK-1:0] apLoad;            // Start recovery timer
  logic [NBANK-1:0] apIdle;            // Recovery timer expired
  logic [7:0]  open_q;                 // Row open per bank
  logic        illegal_q;              // Refused command pulse
  logic [15:0] rdData_q;               // Peek result

  assign bl8   = mode_q[MR_BL8];
  assign wl    = wlOf(mode_q[MR_AL_LO +: 3], mode_q[MR_CL_LO +: 3]);
  assign wrCyc = mode_q[MR_WR_LO +: 3];

  // Mode word is taken only when no write is in flight
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= MODE_RST;
    else if (link.cmd == CMD_MODE && !busy)
      mode_q <= link.addr;
  end

  // Write latency delay line: a write enters at slot wl-1 and
  // reaches slot 0 in the cycle its first data pair is due
  always_ff @(posedge clk)
  begin
    if (rst)
      pValid_q <= '0;
    else
    begin
      for (int i = 0; i < PIPE; i++)
      begin
        if (link.cmd == CMD_WRITE && 4'(i) == 4'(wl - 4'h1))
        begin
          pValid_q[i] <= 1'b1;
          pBank_q[i]  <= link.ba;
          pCol_q[i]   <= link.addr[2:0];
          pAp_q[i]    <= link.addr[ADDR_AP];
        end
        else if (i < PIPE - 1)
        begin
          pValid_q[i] <= pValid_q[i+1];
          pBank_q[i]  <= pBank_q[i+1];
          pCol_q[i]   <= pCol_q[i+1];
          pAp_q[i]    <= pAp_q[i+1];
        end
        else
        begin
          pValid_q[i] <= 1'b0;
          pBank_q[i]  <= 3'h0;
          pCol_q[i]   <= 3'h0;
          pAp_q[i]    <= 1'b0;
        end
      end
    end
  end

  // A new burst replaces a running one: truncation by write only
  assign start  = pValid_q[0];
  assign active = start || (bst_q == BS_BURST);
  assign aBank  = start ? pBank_q[0] : cBank_q;
  assign aCol   = start ? pCol_q[0] : cCol_q;
  assign aBeat  = start ? 2'h0 : beat_q;
  assign lastBeat = (aBeat == (bl8 ? 2'h3 : 2'h1));
  assign busy   = (|pValid_q) || (bst_q == BS_BURST);

  // Burst engine
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bst_q   <= BS_IDLE;
      cBank_q <= 3'h0;
      cCol_q  <= 3'h0;
      cAp_q   <= 1'b0;
      beat_q  <= 2'h0;
    end
    else
    begin
      case (bst_q)
        BS_IDLE, BS_BURST:
        begin
          if (start)
          begin
            // Interrupting write takes over at a prefetch boundary
            bst_q   <= BS_BURST;
            cBank_q <= pBank_q[0];
            cCol_q  <= pCol_q[0];
            cAp_q   <= pAp_q[0];
            beat_q  <= 2'h1;
          end
          else if (active && lastBeat)
            bst_q <= BS_IDLE;
          else if (active)
            beat_q <= 2'(beat_q + 2'h1);
        end
        default:
          bst_q <= BS_IDLE;
      endcase
    end
  end

  // Capture: two elements per pair, each lane under its own strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < NBANK*NCOL; k++)
        mem_q[k] <= 16'h0000;
    end
    else if (active)
    begin
      for (int h = 0; h < 2; h++)
      begin
        for (int l = 0; l < 2; l++)
        begin
          // Lane written only if its strobe toggled and it is unmasked
          if (link.dqs[l] && !link.dm[2*h+l])
            mem_q[{aBank, burstCol(aCol, 3'({aBeat, 1'b0}) + 3'(h), bl8)}][8*l +: 8]
              <= link.dq[16*h + 8*l +: 8];
        end
      end
    end
  end

  // Recovery timer per bank, started at the end of an auto precharge burst
  always_comb
  begin
    apLoad = '0;
    if (active && lastBeat && (start ? pAp_q[0] : cAp_q))
      apLoad[aBank] = 1'b1;
  end

  for (genvar b = 0; b < NBANK; b++)
  begin : g_ap
    gap_timer u_wr (
      .clk   (clk),
      .rst   (rst),
      .load  (apLoad[b]),
      .value ({3'h0, wrCyc}),
      .idle  (apIdle[b])
    );
  end

  // Row state: activate opens, precharge and auto precharge close
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      open_q  <= 8'h00;
      apArm_q <= 8'h00;
    end
    else
    begin
      for (int b = 0; b < NBANK; b++)
      begin
        if (apLoad[b])
          apArm_q[b] <= 1'b1;
        else if (apArm_q[b] && apIdle[b])
        begin
          apArm_q[b] <= 1'b0;
          open_q[b]  <= 1'b0;
        end
        if (link.cmd == CMD_ACT && link.ba == 3'(b))
          open_q[b] <= 1'b1;
        else if (link.cmd == CMD_PRE && !busy &&
                 (link.addr[ADDR_AP] || link.ba == 3'(b)))
          open_q[b] <= 1'b0;
      end
    end
  end

  // Any command but a write is refused while a burst is in flight
  always_ff @(posedge clk)
  begin
    if (rst)
      illegal_q <= 1'b0;
    else
      illegal_q <= busy && link.cmd != CMD_NOP && link.cmd != CMD_WRITE;
  end

  // Storage peek, one cycle behind the index
  always_ff @(posedge clk)
  begin
    if (rst)
      rdData_q <= 16'h0000;
    else
      rdData_q <= mem_q[{rdBank, rdCol}];
  end

  assign rdData     = rdData_q;
  assign bankOpen   = open_q;
  assign illegalCmd = illegal_q;
endmodule : ddr2_wr_device

/* design/ddr2_wr_if.sv */
// Link between memory controller and memory device
`timescale 1ns/10ps
interface ddr2_wr_if (input wire logic clk);
  import ddr2_wr_pkg::*;
  cmd_t        cmd;    // Command, sampled each rising edge
  logic [2:0]  ba;     // Bank address
  logic [12:0] addr;   // Column, auto precharge bit, or mode word
  logic [31:0] dqOut;  // Data pair: [15:0] rising, [31:16] falling
  logic        dqOe;   // Controller drives data
  logic [1:0]  dqs;    // Per-lane strobe: bit0 lower byte, bit1 upper
  logic [3:0]  dm;     // Masks: [1:0] rising lanes, [3:2] falling
  logic [31:0] dq;     // Resolved data wire
  // Undriven wire reads as zero; device never drives in this path
  assign dq = dqOe ? dqOut : 32'h0000_0000;
  modport ctrl (input clk, output cmd, ba, addr, dqOut, dqOe, dqs, dm);
  modport dev  (input clk, cmd, ba, addr, dq, dqOe, dqs, dm);
endinterface : ddr2_wr_if

/* design/ddr2_wr_pkg.sv */
// Shared constants, types and helpers for the write-burst link
package ddr2_wr_pkg;
  // Command codes on the link
  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_READ  = 3'h2,
    CMD_PRE   = 3'h3,
    CMD_ACT   = 3'h4,
    CMD_MODE  = 3'h5
  } cmd_t;
  // Geometry
  localparam int NBANK    = 8;   // Banks
  localparam int NCOL     = 8;   // Columns per bank kept in storage
  localparam int PIPE     = 16;  // Depth of the write-latency delay line
  // Mode word fields, carried on the address lines by CMD_MODE
  localparam int MR_BL8   = 0;   // 1 selects burst of eight, 0 of four
  localparam int MR_AL_LO = 1;   // Additive latency, three bits
  localparam int MR_CL_LO = 4;   // CAS latency, three bits
  localparam int MR_WR_LO = 9;   // Write recovery in cycles, bits 9..11
  localparam int ADDR_AP  = 10;  // Auto precharge / all-banks bit
  localparam logic [12:0] MODE_RST = 13'h0831; // BL8, AL0, CL3, WR4
  // Timing, in picoseconds as printed, and derived cycle counts
  localparam int CLK_PS   = 4000;
  localparam int TWR_PS   = 15000;
  localparam int TWTR_PS  = 7500;
  localparam int TWR_CYC  = (TWR_PS + CLK_PS - 1) / CLK_PS;
  localparam int TWTR_RAW = (TWTR_PS + CLK_PS - 1) / CLK_PS;
  localparam int TWTR_CYC = (TWTR_RAW > 2) ? TWTR_RAW : 2;
  // Register map of the controller, byte addresses
  localparam logic [7:0] REG_MODE   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_WDATA0 = 8'h08; // Four words, 08..14
  localparam logic [7:0] REG_STATUS = 8'h18;
  // Command register fields
  localparam int CR_OP_LO = 0;  // Three bits, cmd_t
  localparam int CR_BA_LO = 4;  // Three bits
  localparam int CR_CO_LO = 8;  // Three bits
  localparam int CR_AP    = 12; // Auto precharge / all banks
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write latency from additive and CAS latency
  function automatic logic [3:0] wlOf(input logic [2:0] al, input logic [2:0] cl);
    wlOf = 4'({1'b0, al} + {1'b0, cl} - 4'h1);
  endfunction : wlOf

  // Column of element n in sequential order, wrapping in the burst
  function automatic logic [2:0] burstCol(input logic [2:0] start, input logic [2:0] n,
                                          input logic bl8);
    logic [2:0] sum;
    sum = 3'(start + n);
    burstCol = bl8 ? sum : {start[2], sum[1:0]};
  endfunction : burstCol
endpackage : ddr2_wr_pkg

/* design/gap_timer.sv */
// Down-counter that reports when a spacing has elapsed
`timescale 1ns/10ps
module gap_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Load a count; idle is high once it has run out
  input  wire logic       load,
  input  wire logic [5:0] value,
  output logic            idle
);
  import ddr2_wr_pkg::*;
  logic [5:0] count_q; // Remaining cycles

  // Load wins over counting
  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= 6'h00;
    else if (load)
      count_q <= value;
    else if (count_q != 6'h00)
      count_q <= 6'(count_q - 6'h01);
  end

  assign idle = (count_q == 6'h00);
endmodule : gap_timer

/* sim/ddr2_wr_assertions.sv */
// Timing checker on the controller-to-device link
`timescale 1ns/10ps
module ddr2_wr_assertions
  import ddr2_wr_pkg::*;
(
  // Link signals
  input wire logic        clk,
  input wire logic        rst,
  input wire cmd_t        cmd,
  input wire logic [2:0]  ba,
  input wire logic [12:0] addr,
  input wire logic        dqOe,
  input wire logic [1:0]  dqs,
  input wire logic [3:0]  dm
);
  logic [5:0] wrAge_q;  // Cycles since last write
  logic [2:0] wrBank_q; // Bank of last write
  // Saturates, so a long idle link never wraps into a false hit
  always_ff @(posedge clk)
    if (rst)
      wrAge_q <= 6'h3F;
    else if (cmd == CMD_WRITE)
      wrAge_q <= 6'h01;
    else if (wrAge_q != 6'h3F)
      wrAge_q <= wrAge_q + 6'h01;
  // Remember the written bank
  always_ff @(posedge clk)
    if (cmd == CMD_WRITE)
      wrBank_q <= ba;
  logic       bl8_q;    // Burst of eight in force on the device
  // Follow the burst length carried by mode commands
  always_ff @(posedge clk)
    if (rst)
      bl8_q <= MODE_RST[MR_BL8];
    else if (cmd == CMD_MODE)
      bl8_q <= addr[MR_BL8];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_write_gap: assert property (cmd == CMD_WRITE |=> cmd != CMD_WRITE ##1
    (!bl8_q || cmd != CMD_WRITE) [*2]) else $error("writes too close");
  a_drive_start: assert property (cmd == CMD_WRITE |-> ##2 dqOe)
    else $error("no data at write latency");
  a_drive_cause: assert property ($rose(dqOe) |-> $past(cmd, 2) == CMD_WRITE)
    else $error("data without a write");
  a_full_burst: assert property ($rose(dqOe) |-> dqOe [*2] ##1 (!bl8_q || dqOe) [*2])
    else $error("burst cut short");
  a_lane_strobe: assert property (dqOe |-> dqs == 2'h3 && dm == 4'h0)
    else $error("lane strobe or mask wrong");
  a_only_writes: assert property (cmd == CMD_WRITE
    |=> (cmd inside {CMD_NOP, CMD_WRITE}) [*3] ##1
    (!bl8_q || cmd inside {CMD_NOP, CMD_WRITE}) [*2]) else $error("command inside burst");
  a_read_wait: assert property (cmd == CMD_READ |-> wrAge_q >= 6'h08)
    else $error("read too soon after write");
  a_pre_recovery: assert property (cmd == CMD_PRE
    && (addr[ADDR_AP] || ba == wrBank_q) |-> wrAge_q >= 6'h0A) else $error("early precharge");
  cover property (cmd == CMD_READ);
  cover property (cmd == CMD_PRE);
  cover property ($fell(dqOe));
endmodule : ddr2_wr_assertions

/* sim/ddr2_write_burst_timing_test.sv */
// Bench joining controller and device over the link
`timescale 1ns/10ps
module ddr2_write_burst_timing_test;
  import ddr2_wr_pkg::*;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, illegalCmd;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, bankOpen;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  rdBank, rdCol;
  logic [15:0] rdData;
  int          err_count, tests_run, n;
  // Rows: bank, start column, first element
  typedef struct {logic [2:0] ba; logic [2:0] co; logic [15:0] d;} row_t;
  row_t rows[3] = '{'{3'h0, 3'h0, 16'hA000}, '{3'h5, 3'h3, 16'hB100}, '{3'h7, 3'h6, 16'hC2F8}};
  ddr2_wr_if ddr2_wr_if_i (.clk);
  ddr2_wr_ctrl ddr2_wr_ctrl_i (.link(ddr2_wr_if_i), .clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  ddr2_wr_device ddr2_wr_device_i (.link(ddr2_wr_if_i), .clk, .rst, .rdBank, .rdCol,
    .rdData, .bankOpen, .illegalCmd);
  ddr2_wr_assertions ddr2_wr_assertions_i (.clk, .rst, .cmd(ddr2_wr_if_i.cmd),
    .ba(ddr2_wr_if_i.ba), .addr(ddr2_wr_if_i.addr), .dqOe(ddr2_wr_if_i.dqOe),
    .dqs(ddr2_wr_if_i.dqs), .dm(ddr2_wr_if_i.dm));
  // A command the device refused is a fault
  always @(posedge clk)
    if (illegalCmd === 1'b1) chk(32'h1, 32'h0);
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic results();
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // A used-up wait bound is a mismatch
  task automatic tmo(input int k);
    chk(32'(k >= 100), 32'h0);
    if (k >= 100)
      results();
  endtask : tmo
  // One AXI4-Lite access; flags sampled mid-cycle, so no edge race
  task automatic axi(input logic we, input logic [7:0] a, inout logic [31:0] d,
                     output logic [1:0] rs);
    logic ta, tw, tb;
    int k;
    @(posedge clk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {{3{we}}, {2{!we}}};
    for (k = 0; k < 100; k++)
    begin
      @(negedge clk);
      {ta, tw, tb} = we ? {awready, wready, bvalid} : {arready, 1'b0, rvalid};
      rs = we ? bresp : rresp;
      d = we ? d : rdata;
      @(posedge clk);
      if (ta)
        {awvalid, arvalid} <= 2'h0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        break;
    end
    {bready, rready} <= 2'h0;
    tmo(k);
  endtask : axi
  // Command register word
  function automatic logic [31:0] cw(cmd_t op, logic [2:0] b, logic [2:0] c, logic ap);
    cw = {19'h0, ap, 1'b0, c, 1'b0, b, 1'b0, op};
  endfunction : cw
  // Issue a command, then wait until neither waiting nor driving
  task automatic go(input logic [31:0] c);
    logic [1:0] rs;
    int k;
    axi(1'b1, REG_CMD, c, rs);
    chk(32'(rs), 32'(RESP_OKAY));
    for (k = 0; k < 100; k++)
    begin
      axi(1'b0, REG_STATUS, c, rs);
      if ((c[0] | c[2]) === 1'b0)
        break;
    end
    tmo(k);
  endtask : go
  // Storage peek, one cycle of latency
  task automatic peek(input logic [2:0] b, input logic [2:0] c, input logic [15:0] e);
    @(posedge clk);
    {rdBank, rdCol} <= {b, c};
    @(posedge clk);
    @(negedge clk);
    chk(32'(rdData), 32'(e));
  endtask : peek
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, wstrb} = 10'h20F;
    {awaddr, araddr, wdata, rdBank, rdCol} = 54'h0;
    {err_count, tests_run} = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axi(1'b0, REG_MODE, v, r);
    chk(32'(v[11:9]), 32'(TWR_CYC));
    // Ordinary bursts: element k lands at start column plus k
    foreach (rows[i])
    begin
      for (int k = 0; k < 4; k++)
      begin
        v = {rows[i].d + 16'(2 * k + 1), rows[i].d + 16'(2 * k)};
        axi(1'b1, REG_WDATA0 + 8'(4 * k), v, r);
      end
      go(cw(CMD_WRITE, rows[i].ba, rows[i].co, 1'b0));
      for (int k = 0; k < 8; k++)
        peek(rows[i].ba, rows[i].co + 3'(k), rows[i].d + 16'(k));
    end
    // Read and precharge right after a write, same bank
    go(cw(CMD_ACT, 3'h2, 3'h0, 1'b0));
    @(negedge clk) chk(32'(bankOpen), 32'h04);
    go(cw(CMD_WRITE, 3'h2, 3'h1, 1'b0));
    go(cw(CMD_READ, 3'h2, 3'h1, 1'b0));
    go(cw(CMD_PRE, 3'h2, 3'h0, 1'b0));
    @(negedge clk);
    chk(32'(bankOpen), 32'h0);
    // Auto precharge closes the row unaided
    go(cw(CMD_ACT, 3'h4, 3'h0, 1'b0));
    @(negedge clk) chk(32'(bankOpen), 32'h10);
    go(cw(CMD_WRITE, 3'h4, 3'h2, 1'b1));
    for (n = 0; n < 100 && bankOpen[4] !== 1'b0; n++)
      @(negedge clk);
    tmo(n);
    // Burst of four after a mode command: columns wrap in four
    v = 32'h0000_0830;
    axi(1'b1, REG_MODE, v, r);
    go(cw(CMD_MODE, 3'h0, 3'h0, 1'b0));
    go(cw(CMD_WRITE, 3'h1, 3'h3, 1'b0));
    for (int k = 0; k < 4; k++)
      peek(3'h1, {1'b0, 2'(3 + k)}, 16'hC2F8 + 16'(k));
    // Unmapped place answers with an error
    axi(1'b1, 8'h1C, v, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi(1'b0, 8'h1C, v, r);
    chk({v[29:0], r}, 32'(RESP_SLVERR));
    results();
  end
endmodule : ddr2_write_burst_timing_test
